// file: hw/nts_top.sv
`timescale 1ns/1ns
// Behaviour
// (R1) Rising chip select after command enters transparent
// (R2) Host prepares transmitter, receiver and front end
// (R3) Transparent: MOSI high drives modulator on
// (R4) Transparent: SCLK level drives receiver_active
// (R5) Transparent: AM to MISO, PM to IRQ
// (R6) Single channel goes to MISO, IRQ low
// (R7) Transparent ignores protocol, framing and FIFO settings
// (R8) Any SPI command ends transparent mode
// (R9) Host gates carrier around each transmit phase
// (R10) Field detect enable routes detector to IRQ; code does so in transparent mode only
// (R11) Field detect with zero control: low power target
// (R12) Host wakes front end on field interrupt
// (R13) Stream bits fill FIFO bytes LSB first
// (R14) Host selects stream mode and its options
// (R15) Host configures analog explicitly for stream mode
// (R16) Sub-carrier from carrier/64 up to carrier/8
// (R17) Reporting period of two to eight sub-carriers
// (R18) First sub-carrier period: start interrupt, first bit
// (R19) One FIFO bit per period, one means sub-carrier
// (R20) End of receive after over eight silent periods
// (R21) Code 01b is carrier/32; code 10b is four periods
// (R22) Type A custom frames via two config bits
// (R23) Each transmit bit period: one modulates, zero not
// (R24) Transmit period code 000b is 128 carrier cycles
// (R25) Commit each eight bits and partial at end
module nts_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic spi_ss_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic am_demod,
    input wire logic pm_demod,
    input wire logic ext_field_det,
    input wire logic carrier_fc,
    input wire logic transparent_cmd,
    input wire logic [1:0] rx_chan_sel,
    input wire logic ext_field_detect_enable,
    input wire logic [7:0] op_ctrl,
    input wire logic [7:0] type_a_cfg,
    input wire logic stream_mode,
    input wire logic [1:0] subcarrier_freq_sel,
    input wire logic [2:0] reporting_period_sel,
    input wire logic [2:0] tx_bit_period_sel,
    input wire logic tx_start,
    input wire logic tx_byte_valid,
    input wire logic [nts_pkg::BYTE_W-1:0] tx_byte_data,
    input wire logic norm_miso,
    input wire logic norm_miso_oe,
    input wire logic norm_irq,
    input wire logic norm_mod,
    output logic miso_out_reg,
    output logic miso_oe_reg,
    output logic irq_reg,
    output logic mod_on_reg,
    output logic receiver_active_reg,
    output logic transparent_reg,
    output logic low_power_target_reg,
    output logic custom_frame_reg,
    output logic rx_sor_reg,
    output logic rx_eor_reg,
    output logic rx_byte_valid_reg,
    output logic [nts_pkg::BYTE_W-1:0] rx_byte_data_reg,
    output logic [3:0] rx_byte_bits_reg,
    output logic tx_byte_take_reg,
    output logic tx_busy_reg
);
    import nts_pkg::*;

    // Pin synchronisers; stage one feeds stage two only.
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_reg;
    logic [PIN_W-1:0] pin_s2_reg;
    logic [PIN_W-1:0] pin_s3_reg;

    assign pin_raw = {carrier_fc, ext_field_det, pm_demod, am_demod,
        spi_mosi, spi_sclk, spi_ss_n};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pin_s1_reg[gi] <= 1'b0;
                    pin_s2_reg[gi] <= 1'b0;
                    pin_s3_reg[gi] <= 1'b0;
                end else begin
                    pin_s1_reg[gi] <= pin_raw[gi];
                    pin_s2_reg[gi] <= pin_s1_reg[gi];
                    pin_s3_reg[gi] <= pin_s2_reg[gi];
                end
            end
        end
    endgenerate

    logic ss_s;
    logic ss_rise;
    logic fc_tick;
    logic sc_edge;
    assign ss_s = pin_s2_reg[PIN_SS_N];
    assign ss_rise = ss_s && !pin_s3_reg[PIN_SS_N];
    assign fc_tick = pin_s2_reg[PIN_FC] && !pin_s3_reg[PIN_FC];
    // The AM demodulator output carries the digitised sub-carrier.
    assign sc_edge = pin_s2_reg[PIN_AM] && !pin_s3_reg[PIN_AM];

    // Transparent mode entry and exit.
    logic armed_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed_reg <= 1'b0;
        end else if (transparent_cmd) begin
            armed_reg <= 1'b1;
        end else if (ss_rise) begin
            armed_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            transparent_reg <= 1'b0;
        end else if (!ss_s) begin
            // A falling select starts a new command and drops the mode.
            transparent_reg <= 1'b0; // [R8]
        end else if (ss_rise && armed_reg) begin
            transparent_reg <= 1'b1; // [R1]
        end
    end

    // Pin multiplexing.
    logic irq_next;
    logic miso_next;
    always_comb begin
        miso_next = norm_miso;
        irq_next = norm_irq;
        if (transparent_reg) begin
            miso_next = pin_s2_reg[PIN_AM]; // [R5]
            irq_next = pin_s2_reg[PIN_PM]; // [R5]
            if (rx_chan_sel == CHAN_PM) begin
                miso_next = pin_s2_reg[PIN_PM]; // [R6]
            end
            if (rx_chan_sel != CHAN_BOTH) begin
                irq_next = 1'b0; // [R6]
            end
            if (ext_field_detect_enable) begin
                irq_next = pin_s2_reg[PIN_EFD]; // [R10]
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            miso_out_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            miso_out_reg <= miso_next;
            miso_oe_reg <= transparent_reg || norm_miso_oe;
            irq_reg <= irq_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            receiver_active_reg <= 1'b0;
            low_power_target_reg <= 1'b0;
            custom_frame_reg <= 1'b0;
        end else begin
            receiver_active_reg <= transparent_reg &&
                pin_s2_reg[PIN_SCLK]; // [R4]
            low_power_target_reg <= ext_field_detect_enable &&
                op_ctrl == 8'h00; // [R11]
            custom_frame_reg <= type_a_cfg[CFG_CUSTOM_HI] ||
                type_a_cfg[CFG_CUSTOM_LO]; // [R22]
        end
    end

    // Stream logic runs only outside transparent mode.
    logic stream_go;
    assign stream_go = stream_mode && !transparent_reg; // [R7]

    // Reporting period length in carrier cycles.
    logic [6:0] sc_div;
    logic [3:0] scp_n;
    logic [9:0] rp_len;
    always_comb begin
        sc_div = SCF_BASE_DIV >> subcarrier_freq_sel; // [R16] [R21]
        scp_n = {1'b0, reporting_period_sel} + SCP_MIN; // [R17] [R21]
        if (scp_n > SCP_MAX) begin
            scp_n = SCP_MAX;
        end
        rp_len = 10'({3'h0, sc_div} * {6'h0, scp_n});
    end

    logic [9:0] rp_cnt_reg;
    logic rp_end;
    assign rp_end = stream_go && fc_tick && rp_cnt_reg == rp_len - 10'h1;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rp_cnt_reg <= '0;
        end else if (!stream_go) begin
            rp_cnt_reg <= '0;
        end else if (rp_end) begin
            rp_cnt_reg <= '0;
        end else if (fc_tick) begin
            rp_cnt_reg <= rp_cnt_reg + 10'h1;
        end
    end

    // An edge in the closing cycle still counts for that period.
    logic seen_reg;
    logic seen_now;
    assign seen_now = seen_reg || sc_edge;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_reg <= 1'b0;
        end else if (rp_end || !stream_go) begin
            seen_reg <= 1'b0;
        end else if (sc_edge) begin
            seen_reg <= 1'b1;
        end
    end

    nts_rx_state_t rx_state_reg;
    logic [3:0] silent_reg;
    logic rx_push;
    logic rx_stop;
    logic rx_begin;
    assign rx_begin = rp_end && rx_state_reg == RX_IDLE && seen_now;
    assign rx_push = rx_begin || (rp_end && rx_state_reg == RX_RUN); // [R19]
    assign rx_stop = rp_end && rx_state_reg == RX_RUN && !seen_now &&
        silent_reg == EOR_SILENT; // [R20]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state_reg <= RX_IDLE;
            silent_reg <= 4'h0;
        end else if (!stream_go) begin
            rx_state_reg <= RX_IDLE;
            silent_reg <= 4'h0;
        end else begin
            case (rx_state_reg)
                RX_IDLE: begin
                    silent_reg <= 4'h0;
                    if (rx_begin) begin
                        rx_state_reg <= RX_RUN; // [R18]
                    end
                end
                RX_RUN: begin
                    if (rx_stop) begin
                        rx_state_reg <= RX_IDLE;
                        silent_reg <= 4'h0;
                    end else if (rp_end) begin
                        silent_reg <= seen_now ? 4'h0 : silent_reg + 4'h1;
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_sor_reg <= 1'b0;
            rx_eor_reg <= 1'b0;
        end else begin
            rx_sor_reg <= rx_begin; // [R18]
            rx_eor_reg <= rx_stop; // [R20]
        end
    end

    nts_pack u_pack (
        .clk(clk),
        .rst(rst),
        .push(rx_push),
        .bit_in(seen_now),
        .flush(rx_stop),
        .byte_valid_reg(rx_byte_valid_reg),
        .byte_data_reg(rx_byte_data_reg),
        .byte_bits_reg(rx_byte_bits_reg)
    );

    // Stream transmitter, one FIFO bit per transmit bit period.
    logic [7:0] tx_len;
    assign tx_len = TX_BASE_DIV >> tx_bit_period_sel; // [R24]

    nts_tx_state_t tx_state_reg;
    logic [7:0] tx_cnt_reg;
    logic [2:0] tx_idx_reg;
    logic [BYTE_W-1:0] tx_sh_reg;
    logic tx_bit_end;
    logic tx_load;
    assign tx_bit_end = tx_state_reg == TX_RUN && fc_tick &&
        tx_cnt_reg == tx_len - 8'h1;
    assign tx_load = tx_byte_valid && ((tx_state_reg == TX_IDLE &&
        tx_start && stream_go) || (tx_bit_end && tx_idx_reg == 3'h7));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg <= 8'h00;
            tx_idx_reg <= 3'h0;
            tx_sh_reg <= '0;
        end else if (!stream_go) begin
            tx_state_reg <= TX_IDLE; // [R7]
            tx_cnt_reg <= 8'h00;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_state_reg <= TX_RUN;
                        tx_sh_reg <= tx_byte_data;
                        tx_idx_reg <= 3'h0;
                        tx_cnt_reg <= 8'h00;
                    end
                end
                TX_RUN: begin
                    if (tx_load) begin
                        tx_sh_reg <= tx_byte_data;
                        tx_idx_reg <= 3'h0;
                        tx_cnt_reg <= 8'h00;
                    end else if (tx_bit_end && tx_idx_reg == 3'h7) begin
                        tx_state_reg <= TX_IDLE;
                        tx_cnt_reg <= 8'h00;
                    end else if (tx_bit_end) begin
                        // Shift right so the first bit sent is the LSB.
                        tx_sh_reg <= tx_sh_reg >> 1; // [R13]
                        tx_idx_reg <= tx_idx_reg + 3'h1;
                        tx_cnt_reg <= 8'h00;
                    end else if (fc_tick) begin
                        tx_cnt_reg <= tx_cnt_reg + 8'h1;
                    end
                end
                default: begin
                    tx_state_reg <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mod_on_reg <= 1'b0;
            tx_byte_take_reg <= 1'b0;
            tx_busy_reg <= 1'b0;
        end else begin
            tx_byte_take_reg <= tx_load && stream_go;
            tx_busy_reg <= tx_state_reg == TX_RUN;
            if (transparent_reg) begin
                mod_on_reg <= pin_s2_reg[PIN_MOSI]; // [R3]
            end else if (tx_state_reg == TX_RUN) begin
                mod_on_reg <= tx_sh_reg[0]; // [R23]
            end else begin
                mod_on_reg <= norm_mod;
            end
        end
    end

    trans_enter_a: assert property ( // [R1]
        @(posedge clk) disable iff (rst)
        ss_rise && armed_reg |=> transparent_reg)
        else $error("transparent mode not entered on select rise");
    trans_exit_a: assert property ( // [R8]
        @(posedge clk) disable iff (rst)
        !ss_s |=> !transparent_reg)
        else $error("transparent mode kept with select low");
    mod_mosi_a: assert property ( // [R3]
        @(posedge clk) disable iff (rst)
        transparent_reg |=> mod_on_reg == $past(pin_s2_reg[PIN_MOSI]))
        else $error("modulator does not follow data in");
    rx_sclk_a: assert property ( // [R4]
        @(posedge clk) disable iff (rst)
        transparent_reg |=>
        receiver_active_reg == $past(pin_s2_reg[PIN_SCLK]))
        else $error("receiver enable does not follow clock pin");
    single_chan_a: assert property ( // [R6]
        @(posedge clk) disable iff (rst)
        transparent_reg && rx_chan_sel != CHAN_BOTH &&
        !ext_field_detect_enable |=> !irq_reg)
        else $error("interrupt pin not low with one channel");
    efd_irq_a: assert property ( // [R10]
        @(posedge clk) disable iff (rst)
        transparent_reg && ext_field_detect_enable |=>
        irq_reg == $past(pin_s2_reg[PIN_EFD]))
        else $error("field detector not on interrupt pin");
    low_power_a: assert property ( // [R11]
        @(posedge clk) disable iff (rst)
        ext_field_detect_enable && op_ctrl == 8'h00 |=>
        low_power_target_reg)
        else $error("low power target mode not flagged");
    sor_first_a: assert property ( // [R18]
        @(posedge clk) disable iff (rst)
        rx_sor_reg |-> $past(rx_push) && $past(seen_now))
        else $error("start of receive without first one bit");
    eor_silent_a: assert property ( // [R20]
        @(posedge clk) disable iff (rst)
        rx_eor_reg |-> $past(silent_reg) == EOR_SILENT)
        else $error("end of receive at wrong silent count");
    tx_idle_a: assert property ( // [R7]
        @(posedge clk) disable iff (rst)
        transparent_reg |=> tx_state_reg == TX_IDLE)
        else $error("stream transmit active in transparent mode");
    tx_len_a: assert property ( // [R24]
        @(posedge clk) disable iff (rst)
        tx_bit_period_sel == 3'h0 |-> tx_len == TX_BASE_DIV)
        else $error("transmit bit period code zero not 128");
endmodule

// file: common/nts_pkg.sv
package nts_pkg;
    // Synchronised pin vector positions.
    localparam int PIN_W = 7;
    localparam int PIN_SS_N = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_MOSI = 2;
    localparam int PIN_AM = 3;
    localparam int PIN_PM = 4;
    localparam int PIN_EFD = 5;
    localparam int PIN_FC = 6;
    // Receiver channel selection codes.
    localparam logic [1:0] CHAN_BOTH = 2'h0;
    localparam logic [1:0] CHAN_AM = 2'h1;
    localparam logic [1:0] CHAN_PM = 2'h2;
    // Sub-carrier stream timing: dividers in carrier cycles, SCP_* in sub-carrier periods, EOR_SILENT in periods.
    localparam logic [6:0] SCF_BASE_DIV = 7'h40;
    localparam logic [3:0] SCP_MIN = 4'h2;
    localparam logic [3:0] SCP_MAX = 4'h8;
    localparam logic [3:0] EOR_SILENT = 4'h8;
    localparam logic [7:0] TX_BASE_DIV = 8'h80;
    // Type A custom frame enable bits of the Type A settings byte.
    localparam int CFG_CUSTOM_LO = 6;
    localparam int CFG_CUSTOM_HI = 7;
    localparam int BYTE_W = 8;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    typedef enum logic [0:0] {RX_IDLE, RX_RUN} nts_rx_state_t;
    typedef enum logic [0:0] {TX_IDLE, TX_RUN} nts_tx_state_t;
endpackage

// file: hw/nts_pack.sv
`timescale 1ns/1ns
module nts_pack (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic bit_in,
    input wire logic flush,
    output logic byte_valid_reg,
    output logic [nts_pkg::BYTE_W-1:0] byte_data_reg,
    output logic [3:0] byte_bits_reg
);
    import nts_pkg::*;

    logic [BYTE_W-1:0] acc_reg;
    logic [BYTE_W-1:0] acc_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic commit;

    always_comb begin
        acc_next = acc_reg;
        if (push) begin
            acc_next[cnt_reg[2:0]] = bit_in; // [R13]
        end
        cnt_next = cnt_reg + {3'h0, push};
        commit = (cnt_next == BYTE_BITS) ||
            (flush && cnt_next != 4'h0); // [R25]
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_reg <= '0;
            cnt_reg <= 4'h0;
        end else if (commit) begin
            acc_reg <= '0;
            cnt_reg <= 4'h0;
        end else begin
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            byte_valid_reg <= 1'b0;
            byte_data_reg <= '0;
            byte_bits_reg <= 4'h0;
        end else begin
            byte_valid_reg <= commit;
            if (commit) begin
                byte_data_reg <= acc_next;
                byte_bits_reg <= cnt_next;
            end
        end
    end

    pack_lsb_a: assert property ( // [R13]
        @(posedge clk) disable iff (rst)
        push && cnt_reg == 4'h0 && !flush |=> acc_reg[0] == $past(bit_in))
        else $error("first stream bit not at byte bit zero");
endmodule

// file: verification/nts_far_model.sv
`timescale 1ns/1ns
module nts_far_model (
    output logic spi_ss_n,
    output logic spi_sclk,
    output logic spi_mosi,
    output logic carrier_fc,
    output logic am_demod
);
    // The carrier runs free, as a crystal-derived carrier does in a reader.
    initial begin
        spi_ss_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
        am_demod = 1'b0;
        carrier_fc = 1'b0;
        #5;
        forever #32 carrier_fc = ~carrier_fc;
    end

    task automatic set_pins(input logic ss, input logic sc, input logic mo);
        spi_ss_n <= ss;
        spi_sclk <= sc;
        spi_mosi <= mo;
    endtask

    task automatic set_am(input logic a);
        am_demod <= a;
    endtask

    // One reporting period of 128 carrier cycles at carrier/32.
    // Bursts sit mid-period so that a few cycles of misalignment between
    // our period and the receiver's period cannot move a bit.
    task automatic rx_period(input logic sc);
        for (int i = 0; i < 128; i++) begin
            @(posedge carrier_fc);
            am_demod <= sc && i >= 32 && i < 96 && (i % 32) >= 8
                && (i % 32) < 24;
        end
    endtask
endmodule

// file: verification/nts_top_test.sv
`timescale 1ns/1ns
module nts_top_test;
    import nts_pkg::*;
    logic clk, rst, ss_n, sclk, mosi, am, pm, efd, fc, cmd, efd_en, strm;
    logic tx_start, tx_valid, nrm;
    logic [1:0] chan, scf;
    logic [2:0] scp, stx;
    logic [7:0] op, cfga, tx_data, rbd, byte0, sor_n, eor_n;
    logic miso, miso_oe, irq, mod_on, rx_act, tp, lpt, cust;
    logic sor, eor, rbv, take, busy;
    logic [3:0] rbb, bits0;
    logic [3:0] tv [8] = '{4'h1, 4'h2, 4'h3, 4'h2, 4'h2, 4'h1, 4'hc, 4'hb};
    logic [1:0] tc [8] = '{CHAN_BOTH, CHAN_BOTH, CHAN_AM, CHAN_AM, CHAN_PM,
        CHAN_PM, CHAN_BOTH, CHAN_BOTH};
    logic [1:0] tx [8] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h2, 2'h0, 2'h1, 2'h2};
    int errors, n_compared;

    nts_far_model u_nts_far_model (.spi_ss_n(ss_n), .spi_sclk(sclk),
        .spi_mosi(mosi), .carrier_fc(fc), .am_demod(am));

    nts_top u_nts_top (.clk(clk), .rst(rst), .spi_ss_n(ss_n),
        .spi_sclk(sclk), .spi_mosi(mosi), .am_demod(am), .pm_demod(pm),
        .ext_field_det(efd), .carrier_fc(fc), .transparent_cmd(cmd),
        .rx_chan_sel(chan), .ext_field_detect_enable(efd_en),
        .op_ctrl(op), .type_a_cfg(cfga), .stream_mode(strm),
        .subcarrier_freq_sel(scf), .reporting_period_sel(scp),
        .tx_bit_period_sel(stx), .tx_start(tx_start),
        .tx_byte_valid(tx_valid), .tx_byte_data(tx_data),
        .norm_miso(nrm), .norm_miso_oe(nrm), .norm_irq(nrm),
        .norm_mod(nrm), .miso_out_reg(miso), .miso_oe_reg(miso_oe),
        .irq_reg(irq), .mod_on_reg(mod_on), .receiver_active_reg(rx_act),
        .transparent_reg(tp), .low_power_target_reg(lpt),
        .custom_frame_reg(cust), .rx_sor_reg(sor), .rx_eor_reg(eor),
        .rx_byte_valid_reg(rbv), .rx_byte_data_reg(rbd),
        .rx_byte_bits_reg(rbb), .tx_byte_take_reg(take),
        .tx_busy_reg(busy));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Receive monitor: keeps the first byte, counts the start/end pulses.
    always @(posedge clk) begin
        if (rst) begin
            sor_n <= 8'h00;
            eor_n <= 8'h00;
            byte0 <= 8'h00;
            bits0 <= 4'h0;
        end else begin
            if (sor)
                sor_n <= sor_n + 8'h01;
            if (eor)
                eor_n <= eor_n + 8'h01;
            if (rbv && byte0 == 8'h00 && bits0 == 4'h0) begin
                byte0 <= rbd;
                bits0 <= rbb;
            end
        end
    end

    initial begin
        cyc(80000);
        errors++;
        close_out();
    end

    initial begin
        {rst, pm, efd, cmd, efd_en, strm, tx_start, tx_valid, nrm} = 9'h100;
        {chan, scf, scp, stx} = 10'h000;
        {op, cfga, tx_data} = 24'h000000;
        cyc(2);
        rst <= 1'b0;
        cyc(3);
        op <= 8'hc8;
        u_nts_far_model.set_pins(1'b0, 1'b0, 1'b0);
        cyc(4);
        cmd <= 1'b1;
        cyc(1);
        cmd <= 1'b0;
        cyc(2);
        u_nts_far_model.set_pins(1'b1, 1'b0, 1'b0);
        cyc(6);
        check(tp, 8'h01);
        check(miso_oe, 8'h01);
        strm <= 1'b1;
        tx_valid <= 1'b1;
        tx_start <= 1'b1;
        cyc(1);
        tx_start <= 1'b0;
        cyc(4);
        check(busy, 8'h00);
        {strm, tx_valid} <= 2'h0;
        for (int k = 0; k < 4; k++) begin
            u_nts_far_model.set_pins(1'b1, k[0], k[1]);
            cyc(6);
            check({mod_on, rx_act}, k[7:0]);
        end
        for (int k = 0; k < 8; k++) begin
            u_nts_far_model.set_am(tv[k][0]);
            pm <= tv[k][1];
            efd <= tv[k][2];
            efd_en <= tv[k][3];
            chan <= tc[k];
            cyc(6);
            check({miso, irq}, tx[k]);
        end
        u_nts_far_model.set_pins(1'b0, 1'b0, 1'b0);
        cyc(6);
        check(tp, 8'h00);
        u_nts_far_model.set_pins(1'b1, 1'b0, 1'b0);
        cyc(6);
        check(tp, 8'h00);
        {efd_en, op} <= 9'h100;
        cyc(3);
        check(lpt, 8'h01);
        op <= 8'h80;
        cyc(3);
        check(lpt, 8'h00);
        u_nts_far_model.set_pins(1'b0, 1'b0, 1'b0);
        op <= 8'hc8;
        cmd <= 1'b1;
        cyc(1);
        cmd <= 1'b0;
        cyc(2);
        u_nts_far_model.set_pins(1'b1, 1'b0, 1'b0);
        cyc(6);
        check(tp, 8'h01);
        u_nts_far_model.set_pins(1'b0, 1'b0, 1'b0);
        op <= 8'h80;
        cyc(6);
        check(tp, 8'h00);
        efd_en <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            cfga <= 8'h40 << k;
            cyc(3);
            check(cust, {7'h00, k < 2});
        end
        chan <= CHAN_BOTH;
        scf <= 2'h1;
        scp <= 3'h2;
        strm <= 1'b1;
        cyc(2);
        for (int k = 0; k < 8; k++)
            u_nts_far_model.rx_period(k[0] ^ k[1] ^ (k < 4));
        check(sor_n, 8'h01);
        // The last pattern period is already silent, so eight silent
        // periods have passed here and the ninth ends the frame.
        repeat (7) u_nts_far_model.rx_period(1'b0);
        check(eor_n, 8'h00);
        repeat (2) u_nts_far_model.rx_period(1'b0);
        check(eor_n, 8'h01);
        check(byte0, 8'h69);
        check(bits0, BYTE_BITS);
        check(sor_n, 8'h01);
        cyc(1);
        stx <= 3'h0;
        tx_data <= 8'h05;
        tx_valid <= 1'b1;
        tx_start <= 1'b1;
        cyc(1);
        tx_start <= 1'b0;
        for (int i = 0; i < 4 && take !== 1'b1; i++)
            cyc(1);
        check(take, 8'h01);
        tx_valid <= 1'b0;
        cyc(1);
        check(mod_on, 8'h01);
        cyc(1900);
        check(mod_on, 8'h01);
        cyc(300);
        check(mod_on, 8'h00);
        cyc(2048);
        check(mod_on, 8'h01);
        cyc(11750);
        check(busy, 8'h01);
        cyc(600);
        check(busy, 8'h00);
        close_out();
    end
endmodule
